// File: core/fcpc_ctrl.sv
// Chosen here: strobed register access.
`timescale 1ns/10ps
`include "fcpc_map.svh"
module fcpc_ctrl #(
  parameter int ADDR_W = 18,
  parameter int LINES = 512,
  parameter int MISS_WAIT = 2,
  parameter int unsigned PAGE_ERASE_CYC =
    (`FCPC_T_PAGE_ERASE_MS * `FCPC_NS_PER_MS) / `FCPC_CLK_NS,
  parameter int unsigned ERASE_ALL_CYC =
    (`FCPC_T_ERASE_ALL_MS * `FCPC_NS_PER_MS) / `FCPC_CLK_NS,
  parameter int unsigned PART_SETUP_CYC =
    (`FCPC_T_PART_SETUP_US * `FCPC_NS_PER_US) / `FCPC_CLK_NS,
  parameter int unsigned CYC_PER_MS = `FCPC_NS_PER_MS / `FCPC_CLK_NS
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic reg_secure,
  output logic [31:0] reg_rdata,
  // flash operation requests
  input wire logic nvm_req,
  input wire fcpc_pkg::fcpc_op_t nvm_kind,
  input wire logic nvm_req_secure,
  input wire logic nvm_page_secure,
  input wire logic [ADDR_W-1:0] nvm_addr,
  input wire logic [31:0] nvm_wdata,
  output logic nvm_ack,
  output logic nvm_bus_error,
  // array drive
  output logic array_write,
  output logic array_erase,
  output logic array_erase_all,
  output logic array_user_config_area_lock,
  output logic [ADDR_W-1:0] array_addr,
  output logic [31:0] array_wdata,
  // protection and power
  input wire logic secure_app_lock_bit,
  input wire logic app_lock_bit,
  input wire logic bulk_erase_lock_bit,
  input wire logic debug_erase_req,
  input wire logic pof_enable,
  input wire logic pof_below,
  // instruction fetch
  input wire logic fetch_req,
  input wire logic [ADDR_W-1:0] fetch_addr,
  output logic fetch_valid,
  output logic [31:0] fetch_data,
  output logic [ADDR_W-1:0] array_rd_addr,
  input wire logic [31:0] array_rd_data
);
  import fcpc_pkg::*;

  localparam int IDX_W = $clog2(LINES);
  localparam int unsigned WRITE_CYC =
    (`FCPC_T_WRITE_US * `FCPC_NS_PER_US) / `FCPC_CLK_NS;

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  // ------------------------------
  // power-fail warning
  // ------------------------------
  logic [2:0] pof_sync;
  logic pof_warn;
  always_ff @(posedge clock) begin
    if (reset) begin
      pof_sync <= 3'h0;
      pof_warn <= 1'b0;
    end else begin
      pof_sync <= {pof_sync[1:0], pof_below};
      if (pof_sync[1] == pof_sync[2]) begin
        pof_warn <= pof_sync[2] & pof_enable;
      end
    end
  end

  // ------------------------------
  // request decode
  // ------------------------------
  logic [1:0] sec_cfg, ns_cfg, icache_cfg;
  logic [`FCPC_PART_MSB:0] partial_cfg;
  fcpc_op_state_t state;
  logic [31:0] op_cnt;
  logic idle, spu_block, req_en, nvm_go, reg_bulk, dbg_go, bulk_go, lock_go;
  logic ctrl_bulk_ok, dbg_bulk_ok;
  logic [1:0] cfg_sel;
  always_comb begin
    idle = (state == FCPC_IDLE);
    spu_block = !nvm_req_secure && nvm_page_secure;
    cfg_sel = nvm_page_secure ? sec_cfg : ns_cfg;
    req_en = (nvm_kind == FCPC_OP_WRITE) ? cfg_sel[`FCPC_CFG_WEN] : cfg_sel[`FCPC_CFG_EEN];
    ctrl_bulk_ok = !secure_app_lock_bit && !app_lock_bit && !bulk_erase_lock_bit;
    dbg_bulk_ok = !bulk_erase_lock_bit;
    reg_bulk = reg_write && reg_secure && reg_addr == `FCPC_OFS_BULK
      && reg_wdata[`FCPC_TRIG_BIT] && sec_cfg[`FCPC_CFG_EEN];
    dbg_go = debug_erase_req && dbg_bulk_ok;
    bulk_go = dbg_go || (reg_bulk && ctrl_bulk_ok);
    lock_go = reg_write && reg_addr == `FCPC_OFS_NS_LOCK && reg_wdata[`FCPC_TRIG_BIT];
    // a register trigger wins the cycle, so a clashing request is refused, not lost
    nvm_go = nvm_req && idle && !spu_block && req_en && !pof_warn
      && !bulk_go && !lock_go;
  end

  // ------------------------------
  // operation sequencer
  // ------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= FCPC_IDLE;
      op_cnt <= 32'h0;
      nvm_ack <= 1'b0;
      nvm_bus_error <= 1'b0;
      array_write <= 1'b0;
      array_erase <= 1'b0;
      array_erase_all <= 1'b0;
      array_user_config_area_lock <= 1'b0;
      array_addr <= '0;
      array_wdata <= 32'h0;
    end else begin
      nvm_ack <= 1'b0;
      nvm_bus_error <= nvm_req && !nvm_go;
      unique case (state)
        FCPC_IDLE: begin
          if ((bulk_go || lock_go) && pof_warn) begin
            nvm_bus_error <= 1'b1;
          end else if (bulk_go) begin
            // factory area is outside the erase scope
            state <= FCPC_ERASE;
            array_erase_all <= 1'b1;
            op_cnt <= ERASE_ALL_CYC - 32'h1;
          end else if (lock_go) begin
            // lock value is all zeros, written into the user area
            state <= FCPC_WRITE;
            array_user_config_area_lock <= 1'b1;
            array_wdata <= 32'h0;
            op_cnt <= WRITE_CYC - 32'h1;
          end else if (nvm_go) begin
            nvm_ack <= 1'b1;
            array_addr <= nvm_addr;
            array_wdata <= nvm_wdata;
            if (nvm_kind == FCPC_OP_WRITE) begin
              state <= FCPC_WRITE;
              array_write <= 1'b1;
              op_cnt <= WRITE_CYC - 32'h1;
            end else begin
              state <= FCPC_ERASE;
              array_erase <= 1'b1;
              if (nvm_kind == FCPC_OP_PAGE_ERASE) begin
                op_cnt <= PAGE_ERASE_CYC - 32'h1;
              end else begin
                op_cnt <= PART_SETUP_CYC - 32'h1
                  + CYC_PER_MS * 32'(partial_cfg);
              end
            end
          end
        end
        FCPC_WRITE: begin
          // a write in flight runs to its end despite the warning
          op_cnt <= op_cnt - 32'h1;
          if (op_cnt == 32'h0) begin
            state <= FCPC_IDLE;
            array_write <= 1'b0;
            array_user_config_area_lock <= 1'b0;
          end
        end
        FCPC_ERASE: begin
          op_cnt <= op_cnt - 32'h1;
          if (pof_warn || op_cnt == 32'h0) begin
            state <= FCPC_IDLE;
            array_erase <= 1'b0;
            array_erase_all <= 1'b0;
            if (pof_warn) begin
              nvm_bus_error <= 1'b1;
            end
          end
        end
        default: state <= FCPC_IDLE;
      endcase
    end
  end

  // ------------------------------
  // register file
  // ------------------------------
  logic [31:0] hit_count, miss_count;
  logic hit_clr, miss_clr;
  always_comb begin
    hit_clr = reg_write && reg_secure && reg_addr == `FCPC_OFS_ICACHE_HIT_COUNT && reg_wdata == 32'h0;
    miss_clr = reg_write && reg_secure && reg_addr == `FCPC_OFS_ICACHE_MISS_COUNT && reg_wdata == 32'h0;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sec_cfg <= 2'h0;
      ns_cfg <= 2'h0;
      icache_cfg <= 2'h0;
      partial_cfg <= `FCPC_PART_RST;
    end else if (reg_write) begin
      // a word with both enables set is dropped to stay one-hot
      if (reg_secure && reg_addr == `FCPC_OFS_SEC_CFG && reg_wdata[1:0] != `FCPC_CFG_BOTH) begin
        sec_cfg <= reg_wdata[1:0];
      end
      if (reg_addr == `FCPC_OFS_NS_CFG && reg_wdata[1:0] != `FCPC_CFG_BOTH) begin
        ns_cfg <= reg_wdata[1:0];
      end
      if (reg_secure && reg_addr == `FCPC_OFS_ICFG) begin
        icache_cfg <= reg_wdata[1:0];
      end
      if (reg_secure && reg_addr == `FCPC_OFS_PARTIAL) begin
        partial_cfg <= reg_wdata[`FCPC_PART_MSB:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= 32'h0;
      if (reg_read) begin
        unique case (reg_addr)
          `FCPC_OFS_READY, `FCPC_OFS_READY_NEXT: reg_rdata <= {31'h0, idle};
          `FCPC_OFS_NS_CFG: reg_rdata <= {30'h0, ns_cfg};
          `FCPC_OFS_SEC_CFG: reg_rdata <= reg_secure ? {30'h0, sec_cfg} : 32'h0;
          `FCPC_OFS_PARTIAL: reg_rdata <= reg_secure ? 32'(partial_cfg) : 32'h0;
          `FCPC_OFS_ICFG: reg_rdata <= reg_secure ? {30'h0, icache_cfg} : 32'h0;
          `FCPC_OFS_ICACHE_HIT_COUNT: reg_rdata <= reg_secure ? hit_count : 32'h0;
          `FCPC_OFS_ICACHE_MISS_COUNT: reg_rdata <= reg_secure ? miss_count : 32'h0;
          default: reg_rdata <= 32'h0;
        endcase
      end
    end
  end

  // ------------------------------
  // instruction cache
  // ------------------------------
  logic [LINES-1:0] line_valid;
  logic [ADDR_W-IDX_W-1:0] tag_mem [LINES];
  logic [31:0] data_mem [LINES];
  fcpc_fetch_state_t fstate;
  logic [7:0] wait_cnt;
  logic cache_en, hit, hit_evt, miss_evt, fill;
  logic [IDX_W-1:0] idx, miss_idx;
  always_comb begin
    cache_en = icache_cfg[`FCPC_ICFG_EN];
    idx = fetch_addr[IDX_W-1:0];
    hit = cache_en && line_valid[idx] && tag_mem[idx] == fetch_addr[ADDR_W-1:IDX_W];
    hit_evt = fetch_req && fstate == FCPC_F_IDLE && hit;
    miss_evt = fetch_req && fstate == FCPC_F_IDLE && !hit;
    // fetches stall while the array is busy programming
    fill = fstate == FCPC_F_MISS && wait_cnt == 8'h0 && idle;
    miss_idx = array_rd_addr[IDX_W-1:0];
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      fstate <= FCPC_F_IDLE;
      wait_cnt <= 8'h0;
      fetch_valid <= 1'b0;
      fetch_data <= 32'h0;
      array_rd_addr <= '0;
    end else begin
      fetch_valid <= 1'b0;
      unique case (fstate)
        FCPC_F_IDLE: begin
          if (hit_evt) begin
            fetch_valid <= 1'b1;
            fetch_data <= data_mem[idx];
          end else if (miss_evt) begin
            fstate <= FCPC_F_MISS;
            array_rd_addr <= fetch_addr;
            wait_cnt <= 8'(MISS_WAIT);
          end
        end
        FCPC_F_MISS: begin
          if (wait_cnt != 8'h0) begin
            wait_cnt <= wait_cnt - 8'h1;
          end else if (fill) begin
            fstate <= FCPC_F_IDLE;
            fetch_valid <= 1'b1;
            fetch_data <= array_rd_data;
          end
        end
      endcase
    end
  end

  // lines are dropped on disable and whenever flash contents change
  always_ff @(posedge clock) begin
    if (reset || !cache_en || !idle) begin
      line_valid <= '0;
    end else if (fill) begin
      line_valid[miss_idx] <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (fill) begin
      tag_mem[miss_idx] <= array_rd_addr[ADDR_W-1:IDX_W];
      data_mem[miss_idx] <= array_rd_data;
    end
  end

  // ------------------------------
  // profiling counters
  // ------------------------------
  logic prof;
  assign prof = cache_en && icache_cfg[`FCPC_ICFG_PROF];
  // a count that lands on a clear is kept, so the counter restarts at one
  always_ff @(posedge clock) begin
    if (reset) begin
      hit_count <= 32'h0;
      miss_count <= 32'h0;
    end else begin
      if (hit_clr) begin
        hit_count <= {31'h0, prof && hit_evt};
      end else if (prof && hit_evt) begin
        hit_count <= hit_count + 32'h1;
      end
      if (miss_clr) begin
        miss_count <= {31'h0, prof && miss_evt};
      end else if (prof && miss_evt) begin
        miss_count <= miss_count + 32'h1;
      end
    end
  end

  // ------------------------------
  // checks
  // ------------------------------
  a_spu_stop: assert property (nvm_req && spu_block |=> nvm_bus_error && !nvm_ack)
    else $error("non-secure write to secure page was not stopped");
  a_pof_refuse: assert property (idle && pof_warn && nvm_req |=> !array_write && !array_erase)
    else $error("operation started under power-fail warning");
  a_write_keeps: assert property (state == FCPC_WRITE && op_cnt != 0 |=> state == FCPC_WRITE)
    else $error("write in flight was cut short");
  a_erase_abort: assert property (state == FCPC_ERASE && pof_warn |=> idle && nvm_bus_error)
    else $error("erase not aborted on power-fail warning");
  a_write_length: assert property ($rose(array_write) |-> op_cnt == WRITE_CYC - 1)
    else $error("word write time wrong");
  a_bulk_locked: assert property (idle && reg_bulk && !ctrl_bulk_ok && !dbg_go
    |=> !array_erase_all)
    else $error("controller bulk erase passed the locks");
  a_dbg_bulk: assert property (idle && debug_erase_req && !bulk_erase_lock_bit && !pof_warn
    |=> array_erase_all)
    else $error("debug bulk erase refused");
  a_hit_zero_wait: assert property (hit_evt |=> fetch_valid)
    else $error("cache hit took a wait state");
  a_miss_wait: assert property (miss_evt |=> !fetch_valid ##[1:1000] fetch_valid)
    else $error("miss answered without flash wait");
  a_flush_off: assert property (!cache_en |=> line_valid == '0)
    else $error("lines survived cache disable");
  a_hit_count: assert property (prof && hit_evt && !hit_clr
    |=> hit_count == $past(hit_count) + 1)
    else $error("hit not counted");
  a_miss_clear: assert property (miss_clr && !miss_evt |=> miss_count == 0)
    else $error("miss counter not cleared");
  a_cfg_onehot: assert property (sec_cfg != `FCPC_CFG_BOTH && ns_cfg != `FCPC_CFG_BOTH)
    else $error("configuration not one-hot");
endmodule // fcpc_ctrl

// File: shared/fcpc_map.svh
`ifndef FCPC_MAP_SVH
`define FCPC_MAP_SVH
// ------------------------------
// register offsets
// ------------------------------
`define FCPC_OFS_READY 12'h400
`define FCPC_OFS_READY_NEXT 12'h408
`define FCPC_OFS_SEC_CFG 12'h504
`define FCPC_OFS_BULK 12'h50c
`define FCPC_OFS_PARTIAL 12'h51c
`define FCPC_OFS_ICFG 12'h540
`define FCPC_OFS_ICACHE_HIT_COUNT 12'h548
`define FCPC_OFS_ICACHE_MISS_COUNT 12'h54c
`define FCPC_OFS_NS_CFG 12'h584
`define FCPC_OFS_NS_LOCK 12'h588
// ------------------------------
// fields and reset values
// ------------------------------
`define FCPC_CFG_WEN 0
`define FCPC_CFG_EEN 1
`define FCPC_CFG_BOTH 2'h3
`define FCPC_TRIG_BIT 0
`define FCPC_ICFG_EN 0
`define FCPC_ICFG_PROF 1
`define FCPC_PART_MSB 6
`define FCPC_PART_RST 7'h0a
// ------------------------------
// timing
// ------------------------------
`define FCPC_CLK_NS 20
`define FCPC_T_WRITE_US 43
`define FCPC_T_PAGE_ERASE_MS 87
`define FCPC_T_ERASE_ALL_MS 173
`define FCPC_T_PART_SETUP_US 1080
`define FCPC_NS_PER_US 1000
`define FCPC_NS_PER_MS 1000000
`endif

// File: shared/fcpc_pkg.sv
package fcpc_pkg;
  typedef enum logic [1:0] {
    FCPC_OP_WRITE,
    FCPC_OP_PAGE_ERASE,
    FCPC_OP_PARTIAL_ERASE
  } fcpc_op_t;
  typedef enum logic [1:0] {FCPC_IDLE, FCPC_WRITE, FCPC_ERASE} fcpc_op_state_t;
  typedef enum logic {FCPC_F_IDLE, FCPC_F_MISS} fcpc_fetch_state_t;
endpackage

// File: sim/fcpc_array_model.sv
`timescale 1ns/10ps
// ------------------------------
// flash array read side
// ------------------------------
module fcpc_array_model #(
  parameter int ADDR_W = 18,
  parameter int MISS_WAIT = 2
) (
  // clock
  input wire logic clock,
  // read port
  input wire logic [ADDR_W-1:0] array_rd_addr,
  output logic [31:0] array_rd_data
);
  logic [ADDR_W-1:0] last_addr = '0;
  int age = 0;
  logic [31:0] word;
  assign word = {{(32-ADDR_W){1'b0}}, array_rd_addr} ^ 32'h5a5a0000;
  always @(posedge clock) begin
    last_addr <= array_rd_addr;
    if (array_rd_addr != last_addr) begin
      age <= 1;
    end else if (age < 100) begin
      age <= age + 1;
    end
  end
  // lines show the inverse until the access time runs out, so a early sample is caught
  assign array_rd_data = (age >= MISS_WAIT) ? word : ~word;
endmodule // fcpc_array_model

// File: sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import fcpc_pkg::*;
  localparam int AW = 18;
  localparam int MW = 2;
  localparam int PE = 40;
  localparam int EA = 50;
  localparam int PS = 20;
  localparam int CM = 5;
  localparam int WC = 2150;
  // ------------------------------
  // signals
  // ------------------------------
  logic clock, reset, reg_write, reg_read, reg_secure, nvm_req, nvm_req_secure;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, nvm_wdata, array_wdata, fetch_data, array_rd_data;
  fcpc_op_t nvm_kind;
  logic nvm_page_secure, nvm_ack, nvm_bus_error, array_write, array_erase;
  logic array_erase_all, array_user_config_area_lock, secure_app_lock_bit, app_lock_bit;
  logic bulk_erase_lock_bit, debug_erase_req, pof_enable, pof_below, fetch_req, fetch_valid;
  logic [AW-1:0] nvm_addr, array_addr, fetch_addr, array_rd_addr;
  int fails = 0;
  int num_checks = 0;
  int berr = 0;
  int n, k;
  fcpc_ctrl #(.ADDR_W(AW), .MISS_WAIT(MW), .PAGE_ERASE_CYC(PE), .ERASE_ALL_CYC(EA),
    .PART_SETUP_CYC(PS), .CYC_PER_MS(CM)) u_dut (.*);
  fcpc_array_model #(.ADDR_W(AW), .MISS_WAIT(MW)) u_array (.*);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) if (nvm_bus_error === 1'b1) berr <= berr + 1;
  initial begin
    repeat (30000) @(posedge clock);
    fails++;
    end_of_test;
  end
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic s);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_secure <= s;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [11:0] a, input logic s, input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_secure <= s;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask
  // exp is {bus error, ack} seen in the cycle after the request
  task automatic req(input fcpc_op_t kd, input logic s, input logic ps, input logic [1:0] exp);
    @(posedge clock);
    nvm_req <= 1'b1;
    nvm_kind <= kd;
    nvm_req_secure <= s;
    nvm_page_secure <= ps;
    @(posedge clock);
    nvm_req <= 1'b0;
    #1;
    check({nvm_bus_error, nvm_ack}, exp);
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return array_write;
      1: return array_erase;
      2: return array_erase_all;
      default: return array_user_config_area_lock;
    endcase
  endfunction
  // cycles the chosen array level stays high; 0 if it has not risen within three cycles
  task automatic dur(input int sel, output int cnt);
    cnt = 0;
    for (int i = 0; i < 3 && sig(sel) !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    while (sig(sel) === 1'b1 && cnt < 3000) begin
      @(posedge clock);
      #1;
      cnt++;
    end
  endtask
  task automatic fetch(input logic [AW-1:0] a, input int lo, input int hi);
    int j;
    @(posedge clock);
    fetch_req <= 1'b1;
    fetch_addr <= a;
    @(posedge clock);
    fetch_req <= 1'b0;
    #1;
    j = 1;
    while (fetch_valid !== 1'b1 && j < 30) begin
      @(posedge clock);
      #1;
      j++;
    end
    check(j >= lo && j <= hi, 32'h1);
    check(fetch_data, {14'h0, a} ^ 32'h5a5a0000);
  endtask
  task automatic pof(input logic v);
    @(posedge clock);
    pof_below <= v;
    repeat (5) @(posedge clock);
  endtask
  // ------------------------------
  // sequence
  // ------------------------------
  initial begin
    reset = 1'b1;
    {reg_write, reg_read, reg_secure, nvm_req, nvm_req_secure, nvm_page_secure} = '0;
    {secure_app_lock_bit, app_lock_bit, bulk_erase_lock_bit, debug_erase_req} = '0;
    {pof_below, fetch_req} = '0;
    pof_enable = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    nvm_kind = FCPC_OP_WRITE;
    nvm_addr = 18'h00123;
    nvm_wdata = 32'h12345678;
    fetch_addr = '0;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rdc(12'h51c, 1'b1, 32'h0a);
    rdc(12'h7fc, 1'b1, 32'h0);
    rdc(12'h400, 1'b0, 32'h1);
    rdc(12'h408, 1'b0, 32'h1);
    wr(12'h504, 32'h3, 1'b1);
    rdc(12'h504, 1'b1, 32'h0);
    req(FCPC_OP_WRITE, 1'b0, 1'b0, 2'b10);
    wr(12'h584, 32'h1, 1'b0);
    rdc(12'h584, 1'b0, 32'h1);
    req(FCPC_OP_WRITE, 1'b0, 1'b1, 2'b10);
    req(FCPC_OP_WRITE, 1'b0, 1'b0, 2'b01);
    check(array_wdata, nvm_wdata);
    check({14'h0, array_addr}, {14'h0, nvm_addr});
    fork
      dur(0, n);
      rdc(12'h400, 1'b0, 32'h0);
    join
    check(n, WC);
    pof(1'b1);
    req(FCPC_OP_WRITE, 1'b0, 1'b0, 2'b10);
    dur(0, n);
    check(n, 0);
    pof(1'b0);
    // second and last write of this word before its page is erased
    req(FCPC_OP_WRITE, 1'b0, 1'b0, 2'b01);
    fork
      dur(0, n);
      begin
        repeat (10) @(posedge clock);
        pof_below <= 1'b1;
      end
    join
    check(n, WC);
    req(FCPC_OP_WRITE, 1'b0, 1'b0, 2'b10);
    req(FCPC_OP_WRITE, 1'b0, 1'b0, 2'b10);
    pof(1'b0);
    wr(12'h504, 32'h2, 1'b1);
    wr(12'h51c, 32'h2, 1'b1);
    req(FCPC_OP_PAGE_ERASE, 1'b1, 1'b1, 2'b01);
    dur(1, n);
    check(n, PE);
    req(FCPC_OP_PARTIAL_ERASE, 1'b1, 1'b1, 2'b01);
    dur(1, n);
    check(n, PS + 2 * CM);
    req(FCPC_OP_PAGE_ERASE, 1'b1, 1'b1, 2'b01);
    k = berr;
    fork
      dur(1, n);
      begin
        repeat (10) @(posedge clock);
        pof_below <= 1'b1;
      end
    join
    repeat (2) @(posedge clock);
    check(n < PE, 32'h1);
    check(berr - k, 32'h1);
    pof(1'b0);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      {bulk_erase_lock_bit, app_lock_bit, secure_app_lock_bit} <= i[2:0];
      wr(12'h50c, 32'h1, 1'b1);
      dur(2, n);
      check(n, (i == 0) ? EA : 0);
      @(posedge clock);
      debug_erase_req <= 1'b1;
      @(posedge clock);
      debug_erase_req <= 1'b0;
      #1;
      dur(2, n);
      check(n, i[2] ? 0 : EA);
    end
    @(posedge clock);
    {bulk_erase_lock_bit, app_lock_bit, secure_app_lock_bit} <= 3'h0;
    wr(12'h588, 32'h1, 1'b0);
    check(array_wdata, 32'h0);
    dur(3, n);
    check(n, WC);
    wr(12'h540, 32'h3, 1'b1);
    fetch(18'h00040, MW + 2, MW + 3);
    fetch(18'h00040, 1, 1);
    rdc(12'h548, 1'b1, 32'h1);
    rdc(12'h54c, 1'b1, 32'h1);
    wr(12'h548, 32'h0, 1'b1);
    rdc(12'h548, 1'b1, 32'h0);
    wr(12'h540, 32'h0, 1'b1);
    wr(12'h540, 32'h3, 1'b1);
    fetch(18'h00040, MW + 2, MW + 3);
    rdc(12'h54c, 1'b1, 32'h2);
    end_of_test;
  end
endmodule // tb_top
